// ### rtl/acs_defines.vh
// Register offsets, field positions, reset values and timing counts
// for the converter sequencer. Included by the sequencer only.
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH
`define ACS_OFF_PORT_A_PINS   8'h05
`define ACS_OFF_PORT_E_PINS   8'h09
`define ACS_OFF_PERIPHERAL_FLAGS_ONE    8'h0C
`define ACS_OFF_RESULT  8'h1E
`define ACS_OFF_CTRL    8'h1F
`define ACS_OFF_DIRA    8'h85
`define ACS_OFF_DIRE    8'h89
`define ACS_OFF_PERIPHERAL_ENABLES_ONE    8'h8C
`define ACS_OFF_PINCFG  8'h9F
`define ACS_RST_CTRL    8'h00
`define ACS_RST_PINCFG  3'h0
`define ACS_RST_DIRA    6'h3F
`define ACS_RST_DIRE    3'h7
`define ACS_RST_FLAGS   8'h00
`define ACS_CTRL_MASK   8'hFD
`define ACS_BIT_ON      0
`define ACS_BIT_GO      2
`define ACS_BIT_CHAN    3
`define ACS_BIT_CLK     6
`define ACS_BIT_DONE    6
`define ACS_CLK_2       2'h0
`define ACS_CLK_8       2'h1
`define ACS_CLK_32      2'h2
`define ACS_CLK_RC      2'h3
`define ACS_HALF_2      4'h0
`define ACS_HALF_8      4'h3
`define ACS_HALF_32     4'hF
`define ACS_CONV_HALVES 5'h13
`define ACS_ABORT_HALVES 5'h04
`define ACS_INSTR_CYC   2'h3
`define ACS_TRIG_MODE   4'hB
`endif

// ### rtl/acs_sequencer.v
// Conversion sequencer of an 8-bit successive-approximation converter:
// register slave, clock select, SAR stepping, abort, sleep and trigger.
// Assumes a core on SYS_CLK drives the register port and the sleep level;
// RC clock, pins and comparator come in asynchronously.
//
// Function
// - A conversion lasts nine and a half bit periods.
// - Bit period is 2, 8 or 32 oscillator periods or RC clock.
// - Output-configured channel pin converts its driven digital level.
// - Port reads return zero for pins set as analog inputs.
// - Clearing start mid-conversion aborts; result keeps old value.
// - Result register writable; read gives last conversion or write.
// - After abort wait two bit periods, then acquisition restarts.
// - RC source waits one instruction cycle; only RC converts in sleep.
// - Completion clears start flag and loads result, also in sleep.
// - Completion in sleep wakes device if interrupt enabled.
// - Non-RC sleep aborts conversion, powers down, power bit stays.
// - Reset disables converter, aborts, makes analog pins analog inputs.
// - Compare mode 1011 with power on sets start, clears timer one.
// - Power off ignores compare event; timer one still cleared.
// - Done flag bit 6 of flags one; enable bit 6 of enables one.
//
// Local design decision: the plain strobed port.
`include "acs_defines.vh"
module acs_sequencer (
    input  wire       SYS_CLK,
    input  wire       SYS_RST,
    input  wire [7:0] REG_ADDR,
    input  wire [7:0] REG_WDATA,
    input  wire       REG_WR,
    input  wire       REG_RD,
    output reg  [7:0] REG_RDATA,
    input  wire       SLEEP_MODE,
    input  wire       RC_CLK_IN,
    input  wire       COMP_HIGH,
    output reg  [7:0] DAC_CODE,
    output reg  [2:0] SAMPLE_CHANNEL,
    output reg        SAMPLE_ACTIVE,
    output reg        CONVERTER_POWERED,
    input  wire [3:0] COMPARE_TWO_MODE,
    input  wire       COMPARE_TWO_EVENT,
    output reg        TIMER_ONE_CLEAR,
    output reg        WAKE_REQUEST,
    output reg        DONE_IRQ_FLAG,
    input  wire [5:0] PORT_A_IN,
    output reg  [5:0] PORT_A_OUT,
    output reg  [5:0] PORT_A_OE_N,
    input  wire [2:0] PORT_E_IN,
    output reg  [2:0] PORT_E_OUT,
    output reg  [2:0] PORT_E_OE_N
);

localparam ST_ACQ   = 2'h0;
localparam ST_DELAY = 2'h1;
localparam ST_CONV  = 2'h2;
localparam ST_ABORT = 2'h3;

////////////////////////////////////////////////////////////////////////
reg  [7:0] ctrl_reg;
reg  [2:0] pincfg_reg;
reg  [7:0] result_reg;
reg  [7:0] flags_reg;
reg  [7:0] enables_reg;
reg  [5:0] dira_reg;
reg  [2:0] dire_reg;
reg  [5:0] lata_reg;
reg  [2:0] late_reg;
reg  [1:0] state_reg;
reg  [4:0] halves_reg;
reg  [3:0] div_reg;
reg  [1:0] delay_reg;
reg  [7:0] sar_reg;
reg  [2:0] rc_sync_reg;
// Synchronised pins: 5..0 port A, 8..6 port E, 9 comparator
wire [9:0] async_sync;
wire [5:0] pa_sync  = async_sync[5:0];
wire [2:0] pe_sync  = async_sync[8:6];
wire       cmp_sync = async_sync[9];

wire [1:0] clk_sel  = ctrl_reg[`ACS_BIT_CLK +: 2];
wire [2:0] chan_sel = ctrl_reg[`ACS_BIT_CHAN +: 3];
wire       power_on = ctrl_reg[`ACS_BIT_ON];
wire       go_bit   = ctrl_reg[`ACS_BIT_GO];
wire       rc_sel   = (clk_sel == `ACS_CLK_RC);
// Non-RC clock stops in sleep, so the analog part is shut down
wire       powered  = power_on & ~(SLEEP_MODE & ~rc_sel);
wire       wr_ctrl  = REG_WR & (REG_ADDR == `ACS_OFF_CTRL);

////////////////////////////////////////////////////////////////////////
// Analog pin map, channels 0..7 in channel order
reg  [7:0] analog_mask;
always @* begin
    case (pincfg_reg)
        3'h0, 3'h1: analog_mask = 8'hFF;
        3'h2, 3'h3: analog_mask = 8'h1F;
        3'h4, 3'h5: analog_mask = 8'h0B;
        default:    analog_mask = 8'h00;
    endcase
end

wire [5:0] mask_a = {analog_mask[4], 1'b0, analog_mask[3:0]};
wire [2:0] mask_e = analog_mask[7:5];
wire [7:0] chan_dir = {dire_reg, dira_reg[5], dira_reg[3:0]};
wire [7:0] chan_lat = {late_reg, lata_reg[5], lata_reg[3:0]};

// Output-configured pin converts its own driven level
wire cmp_bit = chan_dir[chan_sel] ? cmp_sync : chan_lat[chan_sel];

////////////////////////////////////////////////////////////////////////
// Half-period tick: 9.5 periods need half-period resolution
reg  [3:0] half_lim;
always @* begin
    case (clk_sel)
        `ACS_CLK_2: half_lim = `ACS_HALF_2;
        `ACS_CLK_8: half_lim = `ACS_HALF_8;
        default:    half_lim = `ACS_HALF_32;
    endcase
end

wire rc_edge   = rc_sync_reg[2] ^ rc_sync_reg[1];
wire div_done  = (div_reg == half_lim);
wire half_tick = rc_sel ? rc_edge : div_done;

////////////////////////////////////////////////////////////////////////
// Sequencer events
wire conv_run  = (state_reg == ST_CONV);
wire sw_start  = wr_ctrl & REG_WDATA[`ACS_BIT_GO] & power_on
                 & (state_reg == ST_ACQ) & ~go_bit;
wire trig_hit  = COMPARE_TWO_EVENT
                 & (COMPARE_TWO_MODE == `ACS_TRIG_MODE);
wire trig_go   = trig_hit & power_on & (state_reg == ST_ACQ);
wire start     = (sw_start | trig_go) & powered;
wire sw_abort  = wr_ctrl & ~REG_WDATA[`ACS_BIT_GO]
                 & (state_reg == ST_DELAY | conv_run);
wire kill      = ~powered & (state_reg != ST_ACQ);
wire last_half = conv_run & half_tick
                 & (halves_reg == `ACS_CONV_HALVES - 5'h01);
wire complete  = last_half & ~sw_abort & ~kill;
wire [7:0] final_code = sar_reg | (cmp_bit ? DAC_CODE : 8'h00);

////////////////////////////////////////////////////////////////////////
// State machine
reg  [1:0] state_next;
always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_ACQ: begin
            if (start)
                state_next = rc_sel ? ST_DELAY : ST_CONV;
        end
        ST_DELAY: begin
            if (kill)
                state_next = ST_ACQ;
            else if (sw_abort)
                state_next = ST_ABORT;
            else if (delay_reg == `ACS_INSTR_CYC)
                state_next = ST_CONV;
        end
        ST_CONV: begin
            if (kill)
                state_next = ST_ACQ;
            else if (sw_abort)
                state_next = ST_ABORT;
            else if (complete)
                state_next = ST_ACQ;
        end
        ST_ABORT: begin
            if (kill)
                state_next = ST_ACQ;
            else if (half_tick & (halves_reg == `ACS_ABORT_HALVES - 5'h01))
                state_next = ST_ACQ;
        end
        default: state_next = ST_ACQ;
    endcase
end

////////////////////////////////////////////////////////////////////////
// Timing counters and SAR
always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
        state_reg  <= ST_ACQ;
        halves_reg <= 5'h00;
        div_reg    <= 4'h0;
        delay_reg  <= 2'h0;
        sar_reg    <= 8'h00;
        DAC_CODE   <= 8'h00;
    end else begin
        state_reg <= state_next;
        if (state_next != state_reg) begin
            halves_reg <= 5'h00;
            div_reg    <= 4'h0;
            delay_reg  <= 2'h0;
        end else begin
            div_reg   <= div_done ? 4'h0 : div_reg + 4'h1;
            delay_reg <= delay_reg + 2'h1;
            if (half_tick)
                halves_reg <= halves_reg + 5'h01;
        end
        if (state_next == ST_CONV & state_reg != ST_CONV) begin
            sar_reg  <= 8'h00;
            DAC_CODE <= 8'h80;
        end else if (conv_run & half_tick & halves_reg[0]
                     & (halves_reg < 5'h11)) begin
            // One decision per period, MSB first
            sar_reg  <= final_code;
            DAC_CODE <= {1'b0, DAC_CODE[7:1]};
        end
    end
end

////////////////////////////////////////////////////////////////////////
// RC clock: two sync flops, third flop only for edge detection
always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
        rc_sync_reg <= 3'h0;
    end else begin
        rc_sync_reg <= {rc_sync_reg[1:0], RC_CLK_IN};
    end
end

// Two-flop synchronisers, one per pin and comparator bit
// Pins may sit at any level, so metastability is expected here
wire [9:0] async_in = {COMP_HIGH, PORT_E_IN, PORT_A_IN};
genvar gi;
generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_sync
        reg meta_reg;
        reg sync_reg;
        // Only the second flop feeds logic, never the first
        always @(posedge SYS_CLK) begin
            if (SYS_RST) begin
                meta_reg <= 1'b0;
                sync_reg <= 1'b0;
            end else begin
                meta_reg <= async_in[gi];
                sync_reg <= meta_reg;
            end
        end
        assign async_sync[gi] = sync_reg;
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// Register writes and hardware updates
always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
        ctrl_reg    <= `ACS_RST_CTRL;
        pincfg_reg  <= `ACS_RST_PINCFG;
        dira_reg    <= `ACS_RST_DIRA;
        dire_reg    <= `ACS_RST_DIRE;
        flags_reg   <= `ACS_RST_FLAGS;
        enables_reg <= `ACS_RST_FLAGS;
        lata_reg    <= 6'h00;
        late_reg    <= 3'h0;
        result_reg  <= 8'h00;
    end else begin
        if (wr_ctrl)
            ctrl_reg <= {REG_WDATA[7:3], go_bit, 1'b0, REG_WDATA[0]};
        if (start)
            ctrl_reg[`ACS_BIT_GO] <= 1'b1;
        if (sw_abort | kill | complete)
            ctrl_reg[`ACS_BIT_GO] <= 1'b0;
        if (REG_WR) begin
            case (REG_ADDR)
                `ACS_OFF_PINCFG: pincfg_reg  <= REG_WDATA[2:0];
                `ACS_OFF_DIRA:   dira_reg    <= REG_WDATA[5:0];
                `ACS_OFF_DIRE:   dire_reg    <= REG_WDATA[2:0];
                `ACS_OFF_PORT_A_PINS:  lata_reg    <= REG_WDATA[5:0];
                `ACS_OFF_PORT_E_PINS:  late_reg    <= REG_WDATA[2:0];
                `ACS_OFF_PERIPHERAL_ENABLES_ONE:   enables_reg <= REG_WDATA;
                `ACS_OFF_PERIPHERAL_FLAGS_ONE:   flags_reg   <= REG_WDATA;
                `ACS_OFF_RESULT: result_reg  <= REG_WDATA;
                default: ;
            endcase
        end
        // Completion beats a same-cycle software write
        if (complete) begin
            result_reg <= final_code;
            flags_reg[`ACS_BIT_DONE] <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Read data, valid in the cycle after the strobe
reg  [7:0] rd_mux;
always @* begin
    case (REG_ADDR)
        `ACS_OFF_PORT_A_PINS:  rd_mux = {2'h0, pa_sync & ~mask_a};
        `ACS_OFF_PORT_E_PINS:  rd_mux = {5'h00, pe_sync & ~mask_e};
        `ACS_OFF_PERIPHERAL_FLAGS_ONE:   rd_mux = flags_reg;
        `ACS_OFF_PERIPHERAL_ENABLES_ONE:   rd_mux = enables_reg;
        `ACS_OFF_RESULT: rd_mux = result_reg;
        `ACS_OFF_CTRL:   rd_mux = ctrl_reg & `ACS_CTRL_MASK;
        `ACS_OFF_PINCFG: rd_mux = {5'h00, pincfg_reg};
        `ACS_OFF_DIRA:   rd_mux = {2'h0, dira_reg};
        `ACS_OFF_DIRE:   rd_mux = {5'h00, dire_reg};
        default:         rd_mux = 8'h00;
    endcase
end

////////////////////////////////////////////////////////////////////////
// Registered outputs
always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
        REG_RDATA         <= 8'h00;
        SAMPLE_CHANNEL    <= 3'h0;
        SAMPLE_ACTIVE     <= 1'b0;
        CONVERTER_POWERED <= 1'b0;
        TIMER_ONE_CLEAR   <= 1'b0;
        WAKE_REQUEST      <= 1'b0;
        DONE_IRQ_FLAG     <= 1'b0;
        PORT_A_OUT        <= 6'h00;
        PORT_A_OE_N       <= 6'h3F;
        PORT_E_OUT        <= 3'h0;
        PORT_E_OE_N       <= 3'h7;
    end else begin
        REG_RDATA <= REG_RD ? rd_mux : 8'h00;
        SAMPLE_CHANNEL <= chan_sel;
        // Acquisition resumes on its own after the abort wait
        SAMPLE_ACTIVE <= powered & (state_reg == ST_ACQ
                                    | state_reg == ST_DELAY);
        CONVERTER_POWERED <= powered;
        TIMER_ONE_CLEAR <= trig_hit;
        WAKE_REQUEST <= complete & SLEEP_MODE
                        & enables_reg[`ACS_BIT_DONE];
        DONE_IRQ_FLAG <= flags_reg[`ACS_BIT_DONE];
        PORT_A_OUT  <= lata_reg;
        PORT_A_OE_N <= dira_reg;
        PORT_E_OUT  <= late_reg;
        PORT_E_OE_N <= dire_reg;
    end
end

endmodule

// ### test/acs_monitor.sv
// Port checker for the conversion sequencer.
// Assumes one clock domain and a synchronous active-high reset.
module acs_monitor (
    input logic       SYS_CLK,
    input logic       SYS_RST,
    input logic [7:0] REG_ADDR,
    input logic [7:0] REG_WDATA,
    input logic       REG_WR,
    input logic       REG_RD,
    input logic [7:0] REG_RDATA,
    input logic       SLEEP_MODE,
    input logic       CONVERTER_POWERED,
    input logic [3:0] COMPARE_TWO_MODE,
    input logic       COMPARE_TWO_EVENT,
    input logic       TIMER_ONE_CLEAR,
    input logic       WAKE_REQUEST,
    input logic       DONE_IRQ_FLAG,
    input logic [5:0] PORT_A_OE_N,
    input logic [2:0] PORT_E_OE_N
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
////////////////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!$past(REG_RD) |->
        REG_RDATA == 8'h00) else $error("Read data not zero when idle");
    flag_copy_a: assert property (REG_RD && REG_ADDR == 8'h0C |=>
        REG_RDATA[6] == DONE_IRQ_FLAG) else $error("Done flag mismatch");
    timer_clear_a: assert property (COMPARE_TWO_EVENT &&
        COMPARE_TWO_MODE == 4'hB |=> TIMER_ONE_CLEAR)
        else $error("Timer clear missing");
    timer_quiet_a: assert property (!(COMPARE_TWO_EVENT &&
        COMPARE_TWO_MODE == 4'hB) |=> !TIMER_ONE_CLEAR)
        else $error("Timer clear without event");
    // First edge after release must still show reset pin state
    reset_pins_a: assert property ($fell(SYS_RST) |->
        PORT_A_OE_N == 6'h3F && PORT_E_OE_N == 3'h7 && !CONVERTER_POWERED)
        else $error("Pins not analog inputs after reset");
    wake_sleep_a: assert property (WAKE_REQUEST |->
        $past(SLEEP_MODE)) else $error("Wake outside sleep");
    wake_pulse_a: assert property (WAKE_REQUEST |=>
        !WAKE_REQUEST) else $error("Wake longer than one cycle");
    dir_follow_a: assert property (REG_WR && REG_ADDR == 8'h85 |=>
        ##1 PORT_A_OE_N == $past(REG_WDATA[5:0], 2))
        else $error("Direction not on pins");
endmodule
bind acs_sequencer acs_monitor mon (
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .SLEEP_MODE(SLEEP_MODE),
    .CONVERTER_POWERED(CONVERTER_POWERED),
    .COMPARE_TWO_MODE(COMPARE_TWO_MODE),
    .COMPARE_TWO_EVENT(COMPARE_TWO_EVENT),
    .TIMER_ONE_CLEAR(TIMER_ONE_CLEAR), .WAKE_REQUEST(WAKE_REQUEST),
    .DONE_IRQ_FLAG(DONE_IRQ_FLAG), .PORT_A_OE_N(PORT_A_OE_N),
    .PORT_E_OE_N(PORT_E_OE_N)
);

// ### test/testbench.sv
// Self-checking bench for the conversion sequencer.
// Drives all ports itself; makes clock, reset and a slow RC clock.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic       slp = 1'b0, rc = 1'b0, comp = 1'b0, ev = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, dac;
    logic [3:0] mode = 4'h0;
    logic [5:0] pa_in = 6'h3F, pa_out, pa_oe;
    logic [2:0] pe_in = 3'h7, pe_out, pe_oe, chan;
    logic       samp, pwr, tclr, wake, dflag;
    logic [1:0] rcc = 2'h0;
    logic [7:0] ra [7] = '{8'h1F, 8'h9F, 8'h85, 8'h89, 8'h0C, 8'h8C, 8'h00};
    logic [7:0] re [7] = '{8'h00, 8'h00, 8'h3F, 8'h07, 8'h00, 8'h00, 8'h00};
    int         n_mismatch = 0;
    int         n_checks = 0;
    acs_sequencer dut (.SYS_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(rdata), .SLEEP_MODE(slp), .RC_CLK_IN(rc),
        .COMP_HIGH(comp), .DAC_CODE(dac), .SAMPLE_CHANNEL(chan),
        .SAMPLE_ACTIVE(samp), .CONVERTER_POWERED(pwr),
        .COMPARE_TWO_MODE(mode), .COMPARE_TWO_EVENT(ev),
        .TIMER_ONE_CLEAR(tclr), .WAKE_REQUEST(wake), .DONE_IRQ_FLAG(dflag),
        .PORT_A_IN(pa_in), .PORT_A_OUT(pa_out), .PORT_A_OE_N(pa_oe),
        .PORT_E_IN(pe_in), .PORT_E_OUT(pe_out), .PORT_E_OE_N(pe_oe));
////////////////////////////////////////////////////////////////////////////
    initial forever #10 clk = ~clk;
    // RC half period of three clocks, unlike any divider setting
    always @(posedge clk) begin
        rcc <= (rcc == 2'h2) ? 2'h0 : rcc + 2'h1;
        if (rcc == 2'h2) rc <= ~rc;
    end
////////////////////////////////////////////////////////////////////////////
    task chk(input string w, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", w, e, g);
        end
    endtask
    // Gap cycle after each strobe so no signal is set twice at one edge
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a; wdata <= d; reg_wr <= 1'b1;
        @(posedge clk); reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task rd_chk(input string w, input logic [7:0] a, m, e);
        addr <= a; reg_rd <= 1'b1;
        @(posedge clk); reg_rd <= 1'b0;
        #1 chk(w, e, rdata & m);
        @(posedge clk);
    endtask
    task wait_done(output int n, output logic w);
        n = 0; w = 1'b0;
        while (dflag !== 1'b1 && n < 400) begin
            @(posedge clk); #1; n++; w = w | wake;
        end
        @(posedge clk); #1 w = w | wake;
        @(posedge clk);
    endtask
////////////////////////////////////////////////////////////////////////////
    task t_reset;
        for (int i = 0; i < 7; i++) rd_chk("reset reg", ra[i], 8'hFF, re[i]);
        chk("oe port a", 8'h3F, pa_oe);
        chk("oe port e", 8'h07, pe_oe);
        chk("acq off", 8'h00, samp);
    endtask
    task t_ports;
        rd_chk("port a", 8'h05, 8'hFF, 8'h10);
        rd_chk("port e", 8'h09, 8'hFF, 8'h00);
        wr_reg(8'h9F, 8'h06);
        rd_chk("port a dig", 8'h05, 8'hFF, 8'h3F);
        rd_chk("port e dig", 8'h09, 8'hFF, 8'h07);
        wr_reg(8'h09, 8'h05);
        wr_reg(8'h89, 8'h02);
        #1 chk("out port e", 8'h05, pe_out);
        chk("oe port e dir", 8'h02, pe_oe);
        @(posedge clk);
        wr_reg(8'h89, 8'h07);
        wr_reg(8'h9F, 8'h00);
    endtask
    task t_conv;
        int n; logic w; int h;
        for (int s = 0; s < 3; s++) begin
            h = (s == 0) ? 1 : (s == 1) ? 4 : 16;
            comp <= s[0];
            wr_reg(8'h1F, {s[1:0], 6'h01});
            wr_reg(8'h1F, {s[1:0], 6'h05});
            wait_done(n, w);
            chk("time", 1, n >= 19 * h - 1 && n <= 19 * h + 2);
            chk("wake awake", 8'h00, w);
            rd_chk("go", 8'h1F, 8'h04, 8'h00);
            rd_chk("result", 8'h1E, 8'hFF, s[0] ? 8'hFF : 8'h00);
            rd_chk("flag", 8'h0C, 8'h40, 8'h40);
            wr_reg(8'h0C, 8'h00);
        end
    endtask
    task t_abort;
        int n; logic w;
        wr_reg(8'h1E, 8'h5A);
        wr_reg(8'h1F, 8'h41);
        wr_reg(8'h1F, 8'h45);
        repeat (10) @(posedge clk);
        wr_reg(8'h1F, 8'h41);
        wr_reg(8'h1F, 8'h45);
        #1 chk("acq stopped", 8'h00, samp);
        @(posedge clk);
        rd_chk("go in wait", 8'h1F, 8'h04, 8'h00);
        rd_chk("kept", 8'h1E, 8'hFF, 8'h5A);
        rd_chk("no flag", 8'h0C, 8'h40, 8'h00);
        repeat (20) @(posedge clk);
        #1 chk("acq resumed", 8'h01, samp);
        @(posedge clk);
        wr_reg(8'h1F, 8'h45);
        rd_chk("restart", 8'h1F, 8'h04, 8'h04);
        wait_done(n, w);
        rd_chk("new result", 8'h1E, 8'hFF, 8'h00);
        wr_reg(8'h0C, 8'h00);
    endtask
    // Output pin with latch high must convert as full scale
    task t_pin_out;
        int n; logic w;
        wr_reg(8'h05, 8'h01);
        wr_reg(8'h85, 8'h3E);
        #1 chk("oe a", 8'h3E, pa_oe);
        chk("out a", 8'h01, pa_out);
        @(posedge clk);
        wr_reg(8'h1F, 8'h01);
        wr_reg(8'h1F, 8'h05);
        wait_done(n, w);
        rd_chk("pin level", 8'h1E, 8'hFF, 8'hFF);
        wr_reg(8'h0C, 8'h00);
        wr_reg(8'h85, 8'h3F);
    endtask
    task pulse(input logic [7:0] d);
        ev <= 1'b1;
        @(posedge clk); ev <= 1'b0;
        #1 chk("timer clear", 8'h01, tclr);
        chk("trial code", d, dac);
        @(posedge clk);
    endtask
    task t_trig;
        int n; logic w;
        mode <= 4'hB;
        wr_reg(8'h1F, 8'h01);
        repeat (800) @(posedge clk);
        pulse(8'h80);
        rd_chk("trig go", 8'h1F, 8'h04, 8'h04);
        wait_done(n, w);
        rd_chk("trig flag", 8'h0C, 8'h40, 8'h40);
        wr_reg(8'h0C, 8'h00);
        wr_reg(8'h1F, 8'h00);
        pulse(8'h00);
        rd_chk("off ignores", 8'h1F, 8'h04, 8'h00);
    endtask
    task t_sleep;
        wr_reg(8'h1F, 8'h29);
        wr_reg(8'h1F, 8'h2D);
        slp <= 1'b1;
        @(posedge clk); @(posedge clk);
        #1 chk("powered down", 8'h00, pwr);
        chk("channel", 8'h05, chan);
        @(posedge clk);
        rd_chk("on kept", 8'h1F, 8'h05, 8'h01);
        slp <= 1'b0;
        rd_chk("no flag", 8'h0C, 8'h40, 8'h00);
    endtask
    task t_rc;
        int n; logic w;
        wr_reg(8'h8C, 8'h40);
        wr_reg(8'h1F, 8'hC1);
        wr_reg(8'h1F, 8'hC5);
        slp <= 1'b1;
        wait_done(n, w);
        chk("rc time", 1, n > 56);
        chk("wake", 8'h01, w);
        chk("rc powered", 8'h01, pwr);
        slp <= 1'b0;
        rd_chk("rc go", 8'h1F, 8'h05, 8'h01);
        rd_chk("rc flag", 8'h0C, 8'h40, 8'h40);
        wr_reg(8'h0C, 8'h00);
        wr_reg(8'h8C, 8'h00);
    endtask
    task t_mid_reset;
        wr_reg(8'h1F, 8'h45);
        repeat (5) @(posedge clk);
        rst <= 1'b1;
        @(posedge clk); @(posedge clk);
        rst <= 1'b0;
        t_reset();
        repeat (100) @(posedge clk);
        #1 chk("aborted", 8'h00, dflag);
        @(posedge clk);
    endtask
////////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Whole run needs under two thousand cycles; this is far beyond
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_ports();
        t_conv();
        t_abort();
        t_pin_out();
        t_trig();
        t_sleep();
        t_rc();
        t_mid_reset();
        report_and_stop();
    end
endmodule
